// *** iopsw_pkg.sv ***
// Package for the I/O port, sleep, wake-up and reset controller.
// Assumes a single 10 MHz clock and a simple strobe register port.
package iopsw_pkg;

	// ---------------------------------------------------------------
	// Register map (byte-wide registers on a plain strobe port)
	// ---------------------------------------------------------------
	localparam logic [4:0] ADDR_P5_DATA  = 5'h00;
	localparam logic [4:0] ADDR_P6_DATA  = 5'h01;
	localparam logic [4:0] ADDR_P7_DATA  = 5'h02;
	localparam logic [4:0] ADDR_P8_DATA  = 5'h03;
	localparam logic [4:0] ADDR_P5_DIR   = 5'h04;
	localparam logic [4:0] ADDR_P6_DIR   = 5'h05;
	localparam logic [4:0] ADDR_P7_DIR   = 5'h06;
	localparam logic [4:0] ADDR_P8_DIR   = 5'h07;
	localparam logic [4:0] ADDR_PULLUP   = 5'h08;
	localparam logic [4:0] ADDR_PULLDN   = 5'h09;
	localparam logic [4:0] ADDR_OPENDR   = 5'h0A;
	localparam logic [4:0] ADDR_DRIVE    = 5'h0B;
	localparam logic [4:0] ADDR_SINK5    = 5'h0C;
	localparam logic [4:0] ADDR_SINK6    = 5'h0D;
	localparam logic [4:0] ADDR_WAKE_CTL = 5'h0E;
	localparam logic [4:0] ADDR_IRQ_FLAG = 5'h0F;
	localparam logic [4:0] ADDR_WDT_CTL  = 5'h10;
	localparam logic [4:0] ADDR_IRQ_EN   = 5'h11;
	localparam logic [4:0] ADDR_TMR_CTL  = 5'h12;
	localparam logic [4:0] ADDR_BANK_SW  = 5'h13;
	localparam logic [4:0] ADDR_STATUS   = 5'h14;
	localparam logic [4:0] ADDR_CMD      = 5'h15;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int BIT_P6_WAKE    = 4;
	localparam int BIT_CMP_WAKE   = 2;
	localparam int BIT_P6_IRQ_EN  = 1;
	localparam int BIT_CMP_IRQ_EN = 0;
	localparam int BIT_P6_FLAG    = 1;
	localparam int BIT_CMP_FLAG   = 2;
	localparam int BIT_WDT_EN     = 7;
	localparam int BIT_TMR_INTF   = 6;
	localparam int BIT_STS_TO     = 4;
	localparam int BIT_STS_PD     = 3;
	localparam int BIT_CMD_SLEEP  = 0;
	localparam int BIT_CMD_GION   = 1;
	localparam int BIT_CMD_GIOFF  = 2;
	localparam int BIT_CMD_WDTCLR = 3;
	localparam int BIT_CMD_LXT    = 4;
	localparam int BIT_CMD_HXT    = 5;
	localparam logic [7:0]  BYTE_ZERO   = 8'h00;
	localparam logic [7:0]  BYTE_ONES   = 8'hFF;
	localparam logic [7:0]  P5_OUT_ONLY = 8'h0C;
	localparam logic [10:0] PC_RESET    = 11'h000;
	localparam logic [10:0] PC_IRQ_VEC  = 11'h008;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_NS       = 100;
	localparam int RST_HOLD_MS  = 18;
	localparam int RST_LXT_MS   = 500;
	localparam int WAKE_RC_US   = 10;
	localparam int WAKE_HXT_US  = 800;
	localparam int WAKE_LXT_MS  = 2;
	localparam int RST_HOLD_CYC = RST_HOLD_MS * 1000000 / CLK_NS;
	localparam int RST_LXT_CYC  = RST_LXT_MS * 1000000 / CLK_NS;
	localparam int WAKE_RC_CYC  = WAKE_RC_US * 1000 / CLK_NS;
	localparam int WAKE_HXT_CYC = WAKE_HXT_US * 1000 / CLK_NS;
	localparam int WAKE_LXT_CYC = WAKE_LXT_MS * 1000 * 1000000 / CLK_NS;

	// Controller states
	typedef enum logic [1:0] {IOPSW_RUN, IOPSW_RESET_HOLD, IOPSW_SLEEP, IOPSW_WAKE_WAIT} iopsw_state_t;

	// Oscillator mode
	typedef enum logic [1:0] {IOPSW_OSC_RC, IOPSW_OSC_HXT, IOPSW_OSC_LXT} iopsw_osc_t;

	// Register port request
	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} iopsw_bus_t;

	// Core event bundle
	typedef struct packed {
		logic        core_reset;
		logic        osc_stop;
		logic        timer_stop;
		logic        wake_pulse;
		logic        pc_load;
		logic [10:0] pc_value;
	} iopsw_core_t;

endpackage

// *** iopsw_ctrl.sv ***
// Reset, sleep, wake-up and I/O port controller of a small 8-bit microcontroller.
// Assumes pins synchronous to the 10 MHz clock; pad drivers resolve the three signals per pin.
// Functional notes
// - Port pins are three-state, direction per bit; two port 5 pins output only.
// - Software reads and writes port data and direction registers.
// - Pull-up, pull-down, open-drain and drive/sink options held in registers.
// - Reset on power-on, reset pin low, or enabled watchdog time-out.
// - Reset held 18 ms, or 500 ms in low-frequency crystal mode.
// - Reset clears program counter to 000h; oscillator runs or restarts.
// - Reset makes every port pin an input, high impedance, except the two output-only port 5 pins, which drive low.
// - Any reset clears the watchdog counter and prescaler.
// - Bank switch register cleared only by power-on reset.
// - Reset clears timer control except bit 6, which non-power-on resets keep; power-on clears it too.
// - Reset clears interrupt flag, watchdog control and interrupt enable registers.
// - Reset sets pull-up, pull-down and open-drain registers to all ones.
// - Sleep stops oscillator and timer; watchdog cleared but keeps running.
// - Wake on reset pin, watchdog, enabled port 6 change or comparator change.
// - Reset-type wake does full reset; time-out and power-down flags show cause.
// - Change wake vectors to 0x8 if interrupts on, else continues after sleep.
// - Watchdog enabled at sleep disables all change wake enables.
// - Wake delay 10 us RC, 800 us high crystal, seconds in low crystal.
// - Running port 6 change with enable vectors to 008H if interrupts on.
// - Port 6 change sets its flag when its interrupt enable is set.
// - Port 6 change wake enable is bit 4 of the wake control register.
`timescale 1ns/1ps
`default_nettype none

module iopsw_ctrl #(
	parameter int RST_HOLD_CYC = iopsw_pkg::RST_HOLD_CYC,
	parameter int RST_LXT_CYC  = iopsw_pkg::RST_LXT_CYC,
	parameter int WAKE_LXT_CYC = iopsw_pkg::WAKE_LXT_CYC
) (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 nrst,
	// Reset sources
	input  wire logic                 por_event,
	input  wire logic                 ext_reset_n,
	input  wire logic                 wdt_timeout,
	// Analog comparator output level
	input  wire logic                 cmp_out,
	// Register port
	input  wire iopsw_pkg::iopsw_bus_t bus,
	output logic [7:0]                rdata,
	// Port pins, 4 ports of 8
	input  wire logic [31:0]          pin_in,
	output logic [31:0]               pin_out,
	output logic [31:0]               pin_oe,
	output logic [7:0]                pullup_en,
	output logic [7:0]                pulldown_en,
	output logic [7:0]                opendrain_en,
	// Core control
	output iopsw_pkg::iopsw_core_t    core,
	output logic                      wdt_clear
);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	iopsw_pkg::iopsw_state_t state_reg;
	iopsw_pkg::iopsw_osc_t   osc_reg;
	logic [7:0]  data_reg [4];
	logic [7:0]  dir_reg  [4];
	logic [7:0]  pullup_reg, pulldn_reg, opendr_reg, drive_reg, sink5_reg, sink6_reg;
	logic [7:0]  wake_reg, flag_reg, wdtctl_reg, irqen_reg, tmrctl_reg, bank_reg;
	logic        to_reg, pd_reg, gie_reg, gie_sleep_reg, wdt_sleep_reg;
	logic [7:0]  p6_latch_reg;
	logic        cmp_prev_reg;
	logic [31:0] count_reg;
	logic        hold_reg;

	// Reset is requested by any source; pin reset and watchdog act even in sleep
	logic wdt_rst, any_rst, bus_wr, bus_rd, p6_change, cmp_change, irq_take;
	assign wdt_rst    = wdt_timeout && wdtctl_reg[iopsw_pkg::BIT_WDT_EN];
	assign any_rst    = !nrst || por_event || !ext_reset_n || wdt_rst;
	assign bus_wr     = bus.wr && !hold_reg;
	assign bus_rd     = bus.rd && !hold_reg;
	assign p6_change  = |(pin_in[15:8] ^ p6_latch_reg);
	assign cmp_change = cmp_out != cmp_prev_reg;

	// Decode helper: write hit on an address
	function automatic logic hit(input logic [4:0] a);
		hit = bus_wr && (bus.addr == a);
	endfunction

	// Command strobe bit helper
	function automatic logic cmd(input int b);
		cmd = hit(iopsw_pkg::ADDR_CMD) && bus.wdata[b];
	endfunction

	// Reset time depends on oscillator mode
	function automatic logic [31:0] hold_cycles(input iopsw_pkg::iopsw_osc_t o);
		hold_cycles = (o == iopsw_pkg::IOPSW_OSC_LXT) ? RST_LXT_CYC[31:0] : RST_HOLD_CYC[31:0];
	endfunction

	// ---------------------------------------------------------------
	// Sequencer: reset hold, sleep, wake delay
	// ---------------------------------------------------------------
	logic wake_ok;
	// Enables are ignored when watchdog was on at sleep entry
	assign wake_ok = !wdt_sleep_reg &&
		((wake_reg[iopsw_pkg::BIT_P6_WAKE] && p6_change) ||
		 (wake_reg[iopsw_pkg::BIT_CMP_WAKE] && cmp_change));

	// One counter serves both the reset hold and the wake delay
	always_ff @(posedge clock) begin
		if (any_rst) begin
			state_reg <= iopsw_pkg::IOPSW_RESET_HOLD;
			count_reg <= hold_cycles(osc_reg);
		end else begin
			case (state_reg)
				iopsw_pkg::IOPSW_RESET_HOLD: begin
					if (count_reg <= 32'h1)
						state_reg <= iopsw_pkg::IOPSW_RUN;
					count_reg <= count_reg - 32'h1;
				end
				iopsw_pkg::IOPSW_RUN: begin
					if (cmd(iopsw_pkg::BIT_CMD_SLEEP))
						state_reg <= iopsw_pkg::IOPSW_SLEEP;
				end
				iopsw_pkg::IOPSW_SLEEP: begin
					// An armed watchdog at entry leaves only the reset exits
					if (wake_ok) begin
						state_reg <= iopsw_pkg::IOPSW_WAKE_WAIT;
						case (osc_reg)
							iopsw_pkg::IOPSW_OSC_HXT: count_reg <= iopsw_pkg::WAKE_HXT_CYC[31:0];
							iopsw_pkg::IOPSW_OSC_LXT: count_reg <= WAKE_LXT_CYC[31:0];
							default: count_reg <= iopsw_pkg::WAKE_RC_CYC[31:0];
						endcase
					end
				end
				iopsw_pkg::IOPSW_WAKE_WAIT: begin
					if (count_reg <= 32'h1)
						state_reg <= iopsw_pkg::IOPSW_RUN;
					count_reg <= count_reg - 32'h1;
				end
				default: state_reg <= iopsw_pkg::IOPSW_RESET_HOLD;
			endcase
		end
	end

	// Register port stalls while reset is held
	always_ff @(posedge clock) begin
		hold_reg <= any_rst || (state_reg == iopsw_pkg::IOPSW_RESET_HOLD);
	end

	// Oscillator mode survives reset so the hold time can use it
	always_ff @(posedge clock) begin
		if (!nrst)
			osc_reg <= iopsw_pkg::IOPSW_OSC_RC;
		else if (cmd(iopsw_pkg::BIT_CMD_LXT))
			osc_reg <= iopsw_pkg::IOPSW_OSC_LXT;
		else if (cmd(iopsw_pkg::BIT_CMD_HXT))
			osc_reg <= iopsw_pkg::IOPSW_OSC_HXT;
	end

	// ---------------------------------------------------------------
	// Port data, direction and pad options
	// ---------------------------------------------------------------
	// Direction resets to input so no pin fights the board
	always_ff @(posedge clock) begin
		if (any_rst) begin
			for (int i = 0; i < 4; i++) begin
				data_reg[i] <= iopsw_pkg::BYTE_ZERO;
				dir_reg[i]  <= iopsw_pkg::BYTE_ONES;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (hit(iopsw_pkg::ADDR_P5_DATA + 5'(i)))
					data_reg[i] <= bus.wdata;
				if (hit(iopsw_pkg::ADDR_P5_DIR + 5'(i)))
					dir_reg[i] <= bus.wdata;
			end
		end
	end

	// Pad options: pulls and open-drain come up on, strengths off
	always_ff @(posedge clock) begin
		if (any_rst) begin
			pullup_reg <= iopsw_pkg::BYTE_ONES;
			pulldn_reg <= iopsw_pkg::BYTE_ONES;
			opendr_reg <= iopsw_pkg::BYTE_ONES;
			drive_reg  <= iopsw_pkg::BYTE_ZERO;
			sink5_reg  <= iopsw_pkg::BYTE_ZERO;
			sink6_reg  <= iopsw_pkg::BYTE_ZERO;
		end else begin
			if (hit(iopsw_pkg::ADDR_PULLUP)) pullup_reg <= bus.wdata;
			if (hit(iopsw_pkg::ADDR_PULLDN)) pulldn_reg <= bus.wdata;
			if (hit(iopsw_pkg::ADDR_OPENDR)) opendr_reg <= bus.wdata;
			if (hit(iopsw_pkg::ADDR_DRIVE))  drive_reg  <= bus.wdata;
			if (hit(iopsw_pkg::ADDR_SINK5))  sink5_reg  <= bus.wdata;
			if (hit(iopsw_pkg::ADDR_SINK6))  sink6_reg  <= bus.wdata;
		end
	end

	// Pad drive: dir 1 is input; open-drain drives low only
	always_ff @(posedge clock) begin
		for (int i = 0; i < 4; i++) begin
			for (int b = 0; b < 8; b++) begin
				logic drv;
				drv = !dir_reg[i][b] || ((i == 0) && iopsw_pkg::P5_OUT_ONLY[b]);
				if (any_rst) begin
					// Output-only port 5 pins keep driving through reset
					pin_oe[i*8+b]  <= (i == 0) && iopsw_pkg::P5_OUT_ONLY[b];
					pin_out[i*8+b] <= 1'b0;
				end else begin
					pin_out[i*8+b] <= data_reg[i][b];
					pin_oe[i*8+b]  <= drv && !(opendr_reg[b] && data_reg[i][b]);
				end
			end
		end
		pullup_en    <= pullup_reg;
		pulldown_en  <= pulldn_reg;
		opendrain_en <= opendr_reg;
	end

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	// Control registers and the global interrupt enable
	always_ff @(posedge clock) begin
		if (any_rst) begin
			wake_reg   <= iopsw_pkg::BYTE_ZERO;
			wdtctl_reg <= iopsw_pkg::BYTE_ZERO;
			irqen_reg  <= iopsw_pkg::BYTE_ZERO;
			// Power-on has no old edge flag to keep
			if (!nrst || por_event)
				tmrctl_reg <= iopsw_pkg::BYTE_ZERO;
			else
				tmrctl_reg <= tmrctl_reg & (8'h01 << iopsw_pkg::BIT_TMR_INTF);
			gie_reg    <= 1'b0;
		end else begin
			if (hit(iopsw_pkg::ADDR_WAKE_CTL)) wake_reg   <= bus.wdata;
			if (hit(iopsw_pkg::ADDR_WDT_CTL))  wdtctl_reg <= bus.wdata;
			if (hit(iopsw_pkg::ADDR_IRQ_EN))   irqen_reg  <= bus.wdata;
			if (hit(iopsw_pkg::ADDR_TMR_CTL))  tmrctl_reg <= bus.wdata;
			if (cmd(iopsw_pkg::BIT_CMD_GION))       gie_reg <= 1'b1;
			else if (cmd(iopsw_pkg::BIT_CMD_GIOFF)) gie_reg <= 1'b0;
		end
	end

	// Bank switch is cleared by power-on only
	always_ff @(posedge clock) begin
		if (!nrst || por_event)
			bank_reg <= iopsw_pkg::BYTE_ZERO;
		else if (hit(iopsw_pkg::ADDR_BANK_SW))
			bank_reg <= bus.wdata;
	end

	// Sleep entry snapshot of interrupt and watchdog enables
	always_ff @(posedge clock) begin
		if (any_rst) begin
			gie_sleep_reg <= 1'b0;
			wdt_sleep_reg <= 1'b0;
		end else if (state_reg == iopsw_pkg::IOPSW_RUN && cmd(iopsw_pkg::BIT_CMD_SLEEP)) begin
			gie_sleep_reg <= gie_reg;
			wdt_sleep_reg <= wdtctl_reg[iopsw_pkg::BIT_WDT_EN];
		end
	end

	// Cause flags: time-out low after watchdog reset, power-down low after sleep
	always_ff @(posedge clock) begin
		if (!nrst || por_event) begin
			to_reg <= 1'b1;
			pd_reg <= 1'b1;
		end else if (any_rst) begin
			to_reg <= !wdt_rst;
			pd_reg <= state_reg != iopsw_pkg::IOPSW_SLEEP;
		end else if (state_reg == iopsw_pkg::IOPSW_RUN && cmd(iopsw_pkg::BIT_CMD_SLEEP)) begin
			pd_reg <= 1'b0;
		end else if (cmd(iopsw_pkg::BIT_CMD_WDTCLR)) begin
			to_reg <= 1'b1;
			pd_reg <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Change detection and flags
	// ---------------------------------------------------------------
	// Latch reloads on reset so no false change follows it
	always_ff @(posedge clock) begin
		if (any_rst)
			p6_latch_reg <= pin_in[15:8];
		else if (bus_rd && bus.addr == iopsw_pkg::ADDR_P6_DATA)
			p6_latch_reg <= pin_in[15:8];
		cmp_prev_reg <= cmp_out;
	end

	// Set wins over a software clear in the same cycle
	always_ff @(posedge clock) begin
		if (any_rst) begin
			flag_reg <= iopsw_pkg::BYTE_ZERO;
		end else begin
			logic [7:0] f;
			f = hit(iopsw_pkg::ADDR_IRQ_FLAG) ? bus.wdata : flag_reg;
			if (p6_change && irqen_reg[iopsw_pkg::BIT_P6_IRQ_EN])
				f[iopsw_pkg::BIT_P6_FLAG] = 1'b1;
			if (cmp_change && irqen_reg[iopsw_pkg::BIT_CMP_IRQ_EN])
				f[iopsw_pkg::BIT_CMP_FLAG] = 1'b1;
			flag_reg <= f;
		end
	end

	// ---------------------------------------------------------------
	// Core outputs
	// ---------------------------------------------------------------
	// Interrupt taken on a fresh enabled port 6 change while running; the wake vector is loaded below
	assign irq_take = (state_reg == iopsw_pkg::IOPSW_RUN) && gie_reg &&
		p6_change && irqen_reg[iopsw_pkg::BIT_P6_IRQ_EN] && !flag_reg[iopsw_pkg::BIT_P6_FLAG];

	// Core events are registered so the core sees clean levels
	always_ff @(posedge clock) begin
		core.core_reset <= any_rst || (state_reg == iopsw_pkg::IOPSW_RESET_HOLD);
		core.osc_stop   <= !any_rst && (state_reg == iopsw_pkg::IOPSW_SLEEP);
		core.timer_stop <= !any_rst && (state_reg == iopsw_pkg::IOPSW_SLEEP ||
			state_reg == iopsw_pkg::IOPSW_WAKE_WAIT);
		// Watchdog stays cleared for the whole hold so it cannot fire again
		wdt_clear       <= any_rst || (state_reg == iopsw_pkg::IOPSW_RESET_HOLD) ||
			cmd(iopsw_pkg::BIT_CMD_WDTCLR) ||
			(state_reg == iopsw_pkg::IOPSW_RUN && cmd(iopsw_pkg::BIT_CMD_SLEEP));
		core.wake_pulse <= !any_rst && state_reg == iopsw_pkg::IOPSW_WAKE_WAIT && count_reg <= 32'h1;
		// Program counter is held at 000h until the hold ends
		if (any_rst || state_reg == iopsw_pkg::IOPSW_RESET_HOLD) begin
			core.pc_load  <= 1'b1;
			core.pc_value <= iopsw_pkg::PC_RESET;
		end else if (state_reg == iopsw_pkg::IOPSW_WAKE_WAIT && count_reg <= 32'h1) begin
			core.pc_load  <= gie_sleep_reg;
			core.pc_value <= iopsw_pkg::PC_IRQ_VEC;
		end else begin
			core.pc_load  <= irq_take;
			core.pc_value <= iopsw_pkg::PC_IRQ_VEC;
		end
	end

	// Read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clock) begin
		if (!nrst || !bus_rd) begin
			rdata <= iopsw_pkg::BYTE_ZERO;
		end else begin
			case (bus.addr)
				iopsw_pkg::ADDR_P5_DATA:  rdata <= pin_in[7:0];
				iopsw_pkg::ADDR_P6_DATA:  rdata <= pin_in[15:8];
				iopsw_pkg::ADDR_P7_DATA:  rdata <= pin_in[23:16];
				iopsw_pkg::ADDR_P8_DATA:  rdata <= pin_in[31:24];
				iopsw_pkg::ADDR_P5_DIR:   rdata <= dir_reg[0];
				iopsw_pkg::ADDR_P6_DIR:   rdata <= dir_reg[1];
				iopsw_pkg::ADDR_P7_DIR:   rdata <= dir_reg[2];
				iopsw_pkg::ADDR_P8_DIR:   rdata <= dir_reg[3];
				iopsw_pkg::ADDR_PULLUP:   rdata <= pullup_reg;
				iopsw_pkg::ADDR_PULLDN:   rdata <= pulldn_reg;
				iopsw_pkg::ADDR_OPENDR:   rdata <= opendr_reg;
				iopsw_pkg::ADDR_DRIVE:    rdata <= drive_reg;
				iopsw_pkg::ADDR_SINK5:    rdata <= sink5_reg;
				iopsw_pkg::ADDR_SINK6:    rdata <= sink6_reg;
				iopsw_pkg::ADDR_WAKE_CTL: rdata <= wake_reg;
				iopsw_pkg::ADDR_IRQ_FLAG: rdata <= flag_reg;
				iopsw_pkg::ADDR_WDT_CTL:  rdata <= wdtctl_reg;
				iopsw_pkg::ADDR_IRQ_EN:   rdata <= irqen_reg;
				iopsw_pkg::ADDR_TMR_CTL:  rdata <= tmrctl_reg;
				iopsw_pkg::ADDR_BANK_SW:  rdata <= bank_reg;
				iopsw_pkg::ADDR_STATUS:   rdata <= {3'h0, to_reg, pd_reg, gie_reg, 2'h0};
				default:                  rdata <= iopsw_pkg::BYTE_ZERO;
			endcase
		end
	end

endmodule

`default_nettype wire

// *** iopsw_ctrl_checker.sv ***
// Assertion checker for the port, sleep, wake-up and reset controller.
// Assumes it is bound to iopsw_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module iopsw_ctrl_checker (
	// Clock and reset
	input wire logic                   clock,
	input wire logic                   nrst,
	// Observed ports
	input wire logic                   ext_reset_n,
	input wire iopsw_pkg::iopsw_bus_t  bus,
	input wire logic [7:0]             rdata,
	input wire logic [31:0]            pin_oe,
	input wire logic [7:0]             pullup_en,
	input wire logic [7:0]             pulldown_en,
	input wire logic [7:0]             opendrain_en,
	input wire iopsw_pkg::iopsw_core_t core,
	input wire logic                   wdt_clear
);
	// One clock domain, so one clock and one disable serve every property
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// Two-cycle guard: outputs lag the register reset by one edge
	property p_pins_in; $past(core.core_reset, 2) && core.core_reset |-> pin_oe == {24'h0, iopsw_pkg::P5_OUT_ONLY}; endproperty
	a_pins_in: assert property (p_pins_in) else $error("pins driven during reset");
	property p_pc_zero; core.core_reset |-> core.pc_load && core.pc_value == iopsw_pkg::PC_RESET; endproperty
	a_pc_zero: assert property (p_pc_zero) else $error("program counter not cleared in reset");
	property p_wdt_clr; core.core_reset && $past(core.core_reset) |-> wdt_clear; endproperty
	a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared in reset");
	property p_opts; $past(core.core_reset, 2) && core.core_reset |-> (pullup_en & pulldown_en & opendrain_en) == 8'hFF; endproperty
	a_opts: assert property (p_opts) else $error("option registers not all ones in reset");
	property p_pin_rst; !ext_reset_n |-> ##[1:2] core.core_reset; endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("reset pin ignored");
	property p_hold; $rose(core.core_reset) |-> core.core_reset [*8]; endproperty
	a_hold: assert property (p_hold) else $error("reset hold too short");
	property p_sleep; core.osc_stop && $past(core.osc_stop) |-> core.timer_stop; endproperty
	a_sleep: assert property (p_sleep) else $error("timer runs while oscillator stopped");
	property p_vec; core.pc_load && !core.core_reset && !$past(core.core_reset) |-> core.pc_value == iopsw_pkg::PC_IRQ_VEC ##1 !core.pc_load; endproperty
	a_vec: assert property (p_vec) else $error("bad interrupt vector load");
	property p_wake; core.wake_pulse |-> !core.osc_stop ##1 !core.wake_pulse; endproperty
	a_wake: assert property (p_wake) else $error("wake pulse malformed");
	property p_rdata; !$past(bus.rd) |-> rdata == 8'h00; endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
endmodule
bind iopsw_ctrl iopsw_ctrl_checker u_chk (.clock(clock), .nrst(nrst), .ext_reset_n(ext_reset_n), .bus(bus),
	.rdata(rdata), .pin_oe(pin_oe), .pullup_en(pullup_en), .pulldown_en(pulldown_en),
	.opendrain_en(opendrain_en), .core(core), .wdt_clear(wdt_clear));
`default_nettype wire

// *** iopsw_pins.sv ***
// Model of the external pads and board wiring around the port pins.
// Assumes the bench drives the external sources; pull options index by bit.
`timescale 1ns/1ps
`default_nettype none
module iopsw_pins (
	// Clock
	input wire logic         clock,
	// Device side
	input wire logic [31:0]  pin_out,
	input wire logic [31:0]  pin_oe,
	input wire logic [7:0]   pullup_en,
	input wire logic [7:0]   pulldown_en,
	input wire logic [7:0]   opendrain_en,
	// Board side
	input wire logic [31:0]  ext_val,
	input wire logic [31:0]  ext_oe,
	output logic [31:0]      pin_in
);
	logic junk_reg = 1'b0;
	// Floating pins wander, so a stale value can never pass for a driven one
	always_ff @(posedge clock) begin
		junk_reg <= ~junk_reg;
	end
	// Open-drain releases a high; pulls hold an undriven line
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (pin_oe[i] && !(opendrain_en[i % 8] && pin_out[i])) pin_in[i] = pin_out[i];
			else if (ext_oe[i]) pin_in[i] = ext_val[i];
			else if (pullup_en[i % 8]) pin_in[i] = 1'b1;
			else if (pulldown_en[i % 8]) pin_in[i] = 1'b0;
			else pin_in[i] = junk_reg;
		end
	end
endmodule
`default_nettype wire

// *** iopsw_ctrl_bench.sv ***
// Self-checking bench for the port, sleep, wake-up and reset controller.
// Assumes the pad model iopsw_pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin fails++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module iopsw_ctrl_bench;
	logic clock = 0, nrst = 0, por_event = 0, ext_reset_n = 1, wdt_timeout = 0, cmp_out = 0;
	iopsw_pkg::iopsw_bus_t  bus = '0;
	iopsw_pkg::iopsw_core_t core;
	logic [7:0]  rdata, pullup_en, pulldown_en, opendrain_en, d;
	logic [31:0] pin_in, pin_out, pin_oe, ext_val = 32'h0000A500, ext_oe = 32'h0000FF00;
	logic        wdt_clear, s;
	int          fails = 0, n_checks = 0, cyc = 0;
	iopsw_ctrl #(.RST_HOLD_CYC(20), .RST_LXT_CYC(40), .WAKE_LXT_CYC(50)) DUT (.clock(clock), .nrst(nrst),
		.por_event(por_event), .ext_reset_n(ext_reset_n), .wdt_timeout(wdt_timeout), .cmp_out(cmp_out), .bus(bus),
		.rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
		.pulldown_en(pulldown_en), .opendrain_en(opendrain_en), .core(core), .wdt_clear(wdt_clear));
	iopsw_pins u_pins (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
		.pulldown_en(pulldown_en), .opendrain_en(opendrain_en), .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));
	// 100 ns clock
	initial begin
		forever #50 clock = ~clock;
	end
	// Hang guard, well above the several hundred cycles the run needs
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end
	task automatic final_report;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Register port: one-cycle strobes, read data in the following cycle
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge clock) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clock) bus <= '0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge clock) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock) bus <= '0;
		#1 v = rdata;
	endtask
	task automatic wait_run;
		int k;
		k = 0;
		while (core.core_reset !== 1'b0 && k < 400) begin
			@(posedge clock) #1 k++;
		end
		`CHK("reset release", 1'b1, k < 400)
		@(posedge clock);
	endtask
	// Pulses one reset source (0 pin, 1 power-on, 2 watchdog) and notes whether reset followed
	task automatic kick(input int k, output logic seen);
		@(posedge clock) if (k == 0) ext_reset_n <= 0; else if (k == 1) por_event <= 1; else wdt_timeout <= 1;
		@(posedge clock) begin ext_reset_n <= 1; por_event <= 0; wdt_timeout <= 0; end
		seen = 0;
		repeat (4) @(posedge clock) #1 seen |= core.core_reset;
		wait_run();
	endtask
	task automatic t_reset_values;
		`CHK("pin_oe", {24'h0, iopsw_pkg::P5_OUT_ONLY}, pin_oe)
		for (int a = 8; a < 20; a++) begin
			rd(a[4:0], d);
			if (a < 11) `CHK("option reg", 8'hFF, d)
			else if (a > 14) `CHK("cleared reg", 8'h00, d)
		end
	endtask
	task automatic t_ports;
		wr(iopsw_pkg::ADDR_P7_DIR, 8'h00);
		wr(iopsw_pkg::ADDR_P7_DATA, 8'h5A);
		rd(iopsw_pkg::ADDR_P7_DIR, d);
		`CHK("dir readback", 8'h00, d)
		`CHK("port7 out", 16'hA55A, {pin_oe[23:16], pin_out[23:16]})
		rd(iopsw_pkg::ADDR_P7_DATA, d);
		`CHK("port7 pins", 8'h5A, d)
		rd(5'h1F, d);
		`CHK("unmapped", 8'h00, d)
	endtask
	task automatic t_resets;
		wr(iopsw_pkg::ADDR_BANK_SW, 8'h55);
		wr(iopsw_pkg::ADDR_TMR_CTL, 8'hFF);
		kick(0, s);
		`CHK("pin reset", 1'b1, s)
		rd(iopsw_pkg::ADDR_BANK_SW, d);
		`CHK("bank kept", 8'h55, d)
		rd(iopsw_pkg::ADDR_TMR_CTL, d);
		`CHK("timer ctl", 8'h40, d)
		kick(2, s);
		`CHK("wdt off", 1'b0, s)
		wr(iopsw_pkg::ADDR_WDT_CTL, 8'h80);
		kick(2, s);
		`CHK("wdt reset", 1'b1, s)
		kick(1, s);
		rd(iopsw_pkg::ADDR_BANK_SW, d);
		`CHK("bank power-on", 8'h00, d)
	endtask
	task automatic t_p6_irq;
		rd(iopsw_pkg::ADDR_P6_DATA, d);
		wr(iopsw_pkg::ADDR_IRQ_EN, 8'h02);
		wr(iopsw_pkg::ADDR_CMD, 8'h02);
		@(posedge clock) ext_val[12] <= ~ext_val[12];
		s = 0;
		repeat (20) @(posedge clock) #1 s |= core.pc_load && core.pc_value === iopsw_pkg::PC_IRQ_VEC;
		`CHK("run vector", 1'b1, s)
		rd(iopsw_pkg::ADDR_IRQ_FLAG, d);
		`CHK("p6 flag", 1'b1, d[iopsw_pkg::BIT_P6_FLAG])
	endtask
	// Software keeps the pre-sleep sequence: watchdog, port 6 read, global enable, wake enables, interrupt enables, sleep
	task automatic t_sleep(input logic [7:0] wctl, input logic [7:0] gcmd, input logic wdt_on, input logic use_cmp,
		input logic vec);
		logic w, v;
		int   n;
		wr(iopsw_pkg::ADDR_WDT_CTL, wdt_on ? 8'h80 : 8'h00);
		rd(iopsw_pkg::ADDR_P6_DATA, d);
		wr(iopsw_pkg::ADDR_CMD, gcmd);
		wr(iopsw_pkg::ADDR_WAKE_CTL, wctl);
		wr(iopsw_pkg::ADDR_IRQ_EN, 8'h03);
		wr(iopsw_pkg::ADDR_CMD, 8'h01);
		repeat (3) @(posedge clock);
		#1 `CHK("sleep stops", 2'b11, {core.osc_stop, core.timer_stop})
		@(posedge clock) if (use_cmp) cmp_out <= ~cmp_out; else ext_val[9] <= ~ext_val[9];
		w = 0;
		v = 0;
		n = 0;
		for (int k = 0; k < 300; k++) begin
			@(posedge clock) #1 v |= core.pc_load && core.pc_value === iopsw_pkg::PC_IRQ_VEC;
			if (core.wake_pulse === 1'b1 && !w) begin w = 1; n = k; end
			if (w && k > n + 3) break;
		end
		`CHK("woke", !wdt_on, w)
		if (wdt_on) begin
			kick(0, s);
			rd(iopsw_pkg::ADDR_STATUS, d);
			`CHK("reset wake PD", 2'b10, {s, d[iopsw_pkg::BIT_STS_PD]})
		end else begin
			`CHK("wake delay", 1'b1, n >= iopsw_pkg::WAKE_RC_CYC && n <= iopsw_pkg::WAKE_RC_CYC + 8)
			`CHK("wake vector", vec, v)
		end
	endtask
	// Low-frequency crystal hold: reset edge plus the 40-cycle hold set above
	task automatic t_lxt;
		int k;
		wr(iopsw_pkg::ADDR_CMD, 8'h10);
		@(posedge clock) ext_reset_n <= 0;
		@(posedge clock) ext_reset_n <= 1;
		k = 0;
		do @(posedge clock) #1 k++; while (core.core_reset === 1'b1 && k < 99);
		`CHK("lxt hold", 41, k)
	endtask
	initial begin
		repeat (3) @(posedge clock);
		nrst <= 1;
		wait_run();
		t_reset_values();
		t_ports();
		t_resets();
		t_p6_irq();
		t_sleep(8'h10, 8'h04, 1'b0, 1'b0, 1'b0);
		t_sleep(8'h04, 8'h02, 1'b0, 1'b1, 1'b1);
		t_sleep(8'h14, 8'h04, 1'b1, 1'b0, 1'b0);
		t_lxt();
		final_report();
	end
endmodule
`default_nettype wire
